//--- src/sws_stream_top.sv
// Implementation choices: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
// Notes on behaviour
// - Stream pin is read as input after power-up to pick standalone or streaming.
// - Strong pull-up on the stream pin, sampled high, selects streaming mode.
// - In streaming the pin carries only data; motion pin keeps indicating motion.
// - Device starts every frame itself, one after each charge cycle that arrives while streaming with no frame in progress.
// - A frame opens with a start bit: line driven low for the start time.
// - Sync byte 0xAA follows the first start bit; master times bits from it.
// - Exactly twenty data bytes follow the sync byte in every frame.
// - Each byte has start bit before and high stop bit of no fixed length.
// - Byte 0 holds system flags, activation in bit 7 down to zoom in bit 0.
// - Bytes 1-8 counts and averages high first; bytes 9-10 motion filter.
// - Bytes 11-14 thresholds, 15 strap byte, 16-19 multipliers and compensation.
// - Three-level motion strap: low more sensitive, float default, high less.
module sws_stream_top
    import sws_pkg::*;
(
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst_b,
    // Sensing core
    input  wire logic        charge_done,
    input  wire sws_sense_t  sense,
    output logic [1:0]       motion_sens_code,
    // Activation and stream pin
    input  wire logic        stream_pin_i,
    output logic             stream_pin_o,
    output logic             stream_pin_oe,
    // Motion indicator pin
    output logic             motion_indicator_pin_o,
    output logic             motion_indicator_pin_oe,
    // Motion sensitivity strap pin
    input  wire logic        motion_sensitivity_strap_i,
    output logic             motion_sensitivity_strap_o,
    output logic             motion_sensitivity_strap_oe,
    // Avalon-MM slave
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest
);

    typedef enum logic [4:0] {
        S_DRV_HI = 5'b00001,
        S_REL_HI = 5'b00010,
        S_DRV_LO = 5'b00100,
        S_REL_LO = 5'b01000,
        S_RUN    = 5'b10000
    } sws_strap_t;

    typedef enum logic [2:0] {
        F_IDLE = 3'b001,
        F_SYNC = 3'b010,
        F_DATA = 3'b100
    } sws_frame_t;

    sws_strap_t  strap_st;
    sws_strap_t  next_strap_st;
    sws_frame_t  frame_st;
    sws_frame_t  next_frame_st;

    logic [9:0]  settle_cnt;
    logic        streaming;
    logic        mot_hi_seen;
    logic        stream_en;
    logic [15:0] bit_div;
    logic [15:0] bit_cnt;
    logic        overrun;
    logic [7:0]  frame_cnt;
    logic [4:0]  idx;
    logic        ack;
    logic [7:0]  frame_mem [0:DATA_BYTES-1];

    logic        tx_busy;
    logic        tx_done;
    logic        tx_line;

    // Strap sampling sequence
    wire logic settle_end = (settle_cnt == SETTLE_LAST);
    wire logic in_run     = (strap_st == S_RUN);

    always_comb
    begin
        next_strap_st = strap_st;
        case (strap_st)
            S_DRV_HI: if (settle_end) next_strap_st = S_REL_HI;
            S_REL_HI: if (settle_end) next_strap_st = S_DRV_LO;
            S_DRV_LO: if (settle_end) next_strap_st = S_REL_LO;
            S_REL_LO: if (settle_end) next_strap_st = S_RUN;
            S_RUN:    next_strap_st = S_RUN;
            default:  next_strap_st = S_DRV_HI;
        endcase
    end

    wire logic strap_drive = (strap_st == S_DRV_HI) || (strap_st == S_DRV_LO);

    wire logic [1:0] mot_code_w = (mot_hi_seen && motion_sensitivity_strap_i) ? MOT_HIGH :
                                  (!mot_hi_seen && !motion_sensitivity_strap_i) ? MOT_LOW : MOT_DEF;

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            strap_st         <= S_DRV_HI;
            settle_cnt       <= 10'h000;
            streaming        <= 1'b0;
            mot_hi_seen      <= 1'b0;
            motion_sens_code <= MOT_DEF;
        end
        else
        begin
            strap_st   <= next_strap_st;
            settle_cnt <= (settle_end || in_run) ? 10'h000 : settle_cnt + 10'h001;
            if (strap_st == S_REL_HI && settle_end)
                streaming <= stream_pin_i;
            if (strap_st == S_REL_HI && settle_end)
                mot_hi_seen <= motion_sensitivity_strap_i;
            if (strap_st == S_REL_LO && settle_end)
                motion_sens_code <= mot_code_w;
        end
    end

    // Frame contents, byte k at bits 8k+7:8k
    wire logic [7:0] strap_byte = {sense.act_level, sense.timer_sel, motion_sens_code};

    wire logic [FRAME_BITS-1:0] frame_vec = {
        sense.comp1, sense.comp0, sense.mult1, sense.mult0, strap_byte,
        sense.exit_thr[7:0], sense.exit_thr[15:8],
        sense.entry_thr[7:0], sense.entry_thr[15:8],
        sense.motion_filter[7:0], sense.motion_filter[15:8],
        sense.ch1_avg[7:0], sense.ch1_avg[15:8],
        sense.ch1_count[7:0], sense.ch1_count[15:8],
        sense.ch0_avg[7:0], sense.ch0_avg[15:8],
        sense.ch0_count[7:0], sense.ch0_count[15:8],
        sense.flags};

    // Self-started frame on each charge cycle seen while no frame is in progress
    wire logic launch   = (frame_st == F_IDLE) && charge_done && streaming && stream_en && in_run;
    wire logic last_b   = (idx == LAST_IDX);
    wire logic chain    = tx_done && ((frame_st == F_SYNC) || ((frame_st == F_DATA) && !last_b));
    wire logic tx_start = launch || chain;
    wire logic [4:0] next_idx = (frame_st == F_SYNC) ? FIRST_IDX : 5'(idx + 5'h01);
    wire logic [7:0] tx_byte = launch ? SYNC_BYTE : frame_mem[next_idx];
    wire logic ovr_evt  = charge_done && streaming && stream_en && (frame_st != F_IDLE);

    always_comb
    begin
        next_frame_st = frame_st;
        case (frame_st)
            F_IDLE:  if (launch) next_frame_st = F_SYNC;
            F_SYNC:  if (tx_done) next_frame_st = F_DATA;
            F_DATA:  if (tx_done && last_b) next_frame_st = F_IDLE;
            default: next_frame_st = F_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            frame_st  <= F_IDLE;
            idx       <= FIRST_IDX;
            frame_cnt <= 8'h00;
            for (int i = 0; i < DATA_BYTES; i++)
                frame_mem[i] <= 8'h00;
        end
        else
        begin
            frame_st <= next_frame_st;
            if (chain)
                idx <= next_idx;
            if (tx_done && frame_st == F_DATA && last_b)
                frame_cnt <= frame_cnt + 8'h01;
            if (launch)
                for (int i = 0; i < DATA_BYTES; i++)
                    frame_mem[i] <= frame_vec[8*i +: 8];
        end
    end

    // Bit-rate divider, restarted whenever the line is idle
    wire logic [15:0] div_eff  = (bit_div == 16'h0000) ? 16'h0001 : bit_div;
    wire logic        bit_tick = tx_busy && (bit_cnt == 16'(div_eff - 16'h0001));

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            bit_cnt <= 16'h0000;
        else
            bit_cnt <= (!tx_busy || bit_tick) ? 16'h0000 : bit_cnt + 16'h0001;
    end

    // Start, data and stop bits per byte
    sws_byte_tx sws_byte_tx_i (
        .ref_clk  (ref_clk),
        .rst_b    (rst_b),
        .bit_tick (bit_tick),
        .tx_start (tx_start),
        .tx_byte  (tx_byte),
        .tx_busy  (tx_busy),
        .tx_done  (tx_done),
        .tx_line  (tx_line)
    );

    // Pin drivers
    // Stream pin carries data only in streaming
    wire logic next_stream_o = !in_run ? 1'b1 : streaming ? tx_line : !sense.flags[FLG_ACT];

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            stream_pin_o                <= 1'b1;
            stream_pin_oe               <= 1'b0;
            motion_indicator_pin_o      <= 1'b1;
            motion_indicator_pin_oe     <= 1'b1;
            motion_sensitivity_strap_o  <= 1'b1;
            motion_sensitivity_strap_oe <= 1'b1;
        end
        else
        begin
            stream_pin_o                <= next_stream_o;
            stream_pin_oe               <= in_run;
            motion_indicator_pin_o      <= !sense.flags[FLG_MOV];
            motion_indicator_pin_oe     <= 1'b1;
            motion_sensitivity_strap_o  <= (next_strap_st == S_DRV_HI);
            motion_sensitivity_strap_oe <= (next_strap_st == S_DRV_HI) || (next_strap_st == S_DRV_LO);
        end
    end

    // Avalon-MM slave: one wait cycle per access
    wire logic access  = avs_read || avs_write;
    wire logic wr_go   = avs_write && ack;
    wire logic sel_ctl = (avs_address == OFS_CTRL);
    wire logic sel_sts = (avs_address == OFS_STATUS);
    wire logic sel_div = (avs_address == OFS_BIT_DIV);
    wire logic ovr_clr = wr_go && sel_sts && avs_byteenable[0] && avs_writedata[STS_OVR];

    assign avs_waitrequest = access && !ack;

    wire logic [31:0] sts_word = {16'h0000, frame_cnt, 3'h0, overrun,
                                  (frame_st != F_IDLE), motion_sens_code, streaming};
    wire logic [31:0] rd_mux = sel_ctl ? {31'h0000_0000, stream_en} :
                               sel_sts ? sts_word :
                               sel_div ? {16'h0000, bit_div} : RD_ZERO;

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ack          <= 1'b0;
            avs_readdata <= RD_ZERO;
            stream_en    <= CTRL_EN_RST;
            bit_div      <= BIT_DIV_RST;
            overrun      <= 1'b0;
        end
        else
        begin
            ack <= access && !ack;
            if (avs_read && !ack)
                avs_readdata <= rd_mux;
            if (wr_go && sel_ctl && avs_byteenable[0])
                stream_en <= avs_writedata[CTRL_EN_BIT];
            if (wr_go && sel_div && avs_byteenable[0])
                bit_div[7:0] <= avs_writedata[7:0];
            if (wr_go && sel_div && avs_byteenable[1])
                bit_div[15:8] <= avs_writedata[15:8];
            // Set wins over clear
            if (ovr_evt)
                overrun <= 1'b1;
            else if (ovr_clr)
                overrun <= 1'b0;
        end
    end

endmodule : sws_stream_top

//--- src/sws_pkg.sv
package sws_pkg;

    // Clock and strap timing
    localparam int CLK_PERIOD_NS     = 20;
    localparam int STRAP_SETTLE_NS   = 10_000;
    localparam int STRAP_SETTLE_CYC  = (STRAP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [9:0] SETTLE_LAST = 10'(STRAP_SETTLE_CYC - 1);

    // Frame layout
    localparam logic [7:0] SYNC_BYTE  = 8'hAA;
    localparam int         DATA_BYTES = 20;
    localparam int         FRAME_BITS = 8 * DATA_BYTES;
    localparam logic [4:0] LAST_IDX   = 5'h13;
    localparam logic [4:0] FIRST_IDX  = 5'h00;

    // Bit timing in bit-rate ticks
    localparam logic [3:0] START_BIT_TICKS = 4'h1;
    localparam logic [3:0] DATA_BIT_TICKS  = 4'h8;
    localparam logic [3:0] STOP_BIT_TICKS  = 4'h1;

    // Flag byte positions
    localparam int FLG_ACT = 7;
    localparam int FLG_MOV = 6;

    // Motion sensitivity strap codes
    localparam logic [1:0] MOT_LOW  = 2'h0;
    localparam logic [1:0] MOT_DEF  = 2'h1;
    localparam logic [1:0] MOT_HIGH = 2'h2;

    // Register byte offsets
    localparam logic [3:0] OFS_CTRL    = 4'h0;
    localparam logic [3:0] OFS_STATUS  = 4'h4;
    localparam logic [3:0] OFS_BIT_DIV = 4'h8;

    // Control and status fields
    localparam int CTRL_EN_BIT  = 0;
    localparam int STS_STREAM   = 0;
    localparam int STS_MOT_LSB  = 1;
    localparam int STS_BUSY     = 3;
    localparam int STS_OVR      = 4;
    localparam int STS_CNT_LSB  = 8;

    // Reset values
    localparam logic        CTRL_EN_RST = 1'b1;
    localparam logic [15:0] BIT_DIV_RST = 16'h0064;
    localparam logic [31:0] RD_ZERO     = 32'h0000_0000;

    // Values captured from the sensing core at each charge cycle
    typedef struct packed {
        logic [7:0]  flags;
        logic [15:0] ch0_count;
        logic [15:0] ch0_avg;
        logic [15:0] ch1_count;
        logic [15:0] ch1_avg;
        logic [15:0] motion_filter;
        logic [15:0] entry_thr;
        logic [15:0] exit_thr;
        logic [3:0]  act_level;
        logic [1:0]  timer_sel;
        logic [7:0]  mult0;
        logic [7:0]  mult1;
        logic [7:0]  comp0;
        logic [7:0]  comp1;
    } sws_sense_t;

endpackage : sws_pkg

//--- src/sws_byte_tx.sv
`timescale 1ns/10ps
module sws_byte_tx
    import sws_pkg::*;
(
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst_b,
    // Bit rate
    input  wire logic       bit_tick,
    // Byte request
    input  wire logic       tx_start,
    input  wire logic [7:0] tx_byte,
    output logic            tx_busy,
    output logic            tx_done,
    // Line level
    output logic            tx_line
);

    typedef enum logic [3:0] {
        P_IDLE  = 4'b0001,
        P_START = 4'b0010,
        P_BITS  = 4'b0100,
        P_STOP  = 4'b1000
    } sws_phase_t;

    sws_phase_t phase;
    sws_phase_t next_phase;
    logic [7:0] shreg;
    logic [3:0] cnt;

    wire logic last = bit_tick && (cnt == 4'h1);
    wire logic load = tx_start && ((phase == P_IDLE) || ((phase == P_STOP) && last));

    assign tx_busy = (phase != P_IDLE);
    assign tx_done = last && (phase == P_STOP);
    assign tx_line = (phase == P_START) ? 1'b0 : (phase == P_BITS) ? shreg[0] : 1'b1;

    always_comb
    begin
        next_phase = phase;
        case (phase)
            P_IDLE:  if (tx_start) next_phase = P_START;
            P_START: if (last) next_phase = P_BITS;
            P_BITS:  if (last) next_phase = P_STOP;
            P_STOP:  if (last) next_phase = tx_start ? P_START : P_IDLE;
            default: next_phase = P_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            phase <= P_IDLE;
            cnt   <= 4'h0;
            shreg <= 8'h00;
        end
        else
        begin
            phase <= next_phase;
            if (load)
            begin
                cnt   <= START_BIT_TICKS;
                shreg <= tx_byte;
            end
            else if (last && phase == P_START)
                cnt <= DATA_BIT_TICKS;
            else if (last && phase == P_BITS)
                cnt <= STOP_BIT_TICKS;
            else if (bit_tick)
                cnt <= cnt - 4'h1;
            if (bit_tick && phase == P_BITS)
                shreg <= {1'b1, shreg[7:1]};
        end
    end

endmodule : sws_byte_tx

//--- dv/sws_stream_top_sva.sv
`timescale 1ns/10ps
module sws_stream_chk
    import sws_pkg::*;
#(
    parameter int IDLE_CYC = 1000
)
(
    // Clock and reset
    input wire logic        ref_clk,
    input wire logic        rst_b,
    // Sensing core
    input wire logic        charge_done,
    input wire sws_sense_t  sense,
    input wire logic [1:0]  motion_sens_code,
    // Pins
    input wire logic        stream_pin_i,
    input wire logic        stream_pin_o,
    input wire logic        stream_pin_oe,
    input wire logic        motion_indicator_pin_o,
    input wire logic        motion_indicator_pin_oe,
    input wire logic        motion_sensitivity_strap_oe,
    // Avalon-MM
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic        avs_waitrequest
);
    logic [11:0] up_cnt;
    logic [11:0] hi_cnt;
    logic        strm;
    wire         req  = avs_read | avs_write;
    wire         idle = strm && stream_pin_oe && (hi_cnt > 12'(IDLE_CYC));

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    // Level of the released stream pin is the strapped mode
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            up_cnt <= 12'h000;
            hi_cnt <= 12'h000;
            strm   <= 1'b0;
        end
        else
        begin
            up_cnt <= (&up_cnt) ? up_cnt : up_cnt + 12'h001;
            hi_cnt <= !stream_pin_o ? 12'h000 : ((&hi_cnt) ? hi_cnt : hi_cnt + 12'h001);
            strm   <= stream_pin_oe ? strm : stream_pin_i;
        end
    end

    sequence s_launch;
        idle && charge_done;
    endsequence

    sequence s_held_wait;
        req && avs_waitrequest ##1 req;
    endsequence

    a_probe_quiet: assert property (up_cnt < 12'h7C6 |-> !stream_pin_oe)
        else $error("stream pin driven while straps are probed");
    a_strap_free: assert property (up_cnt > 12'h7DA |-> !motion_sensitivity_strap_oe && $stable(motion_sens_code))
        else $error("motion strap still driven or code moved");
    a_frame_start: assert property (s_launch |-> ##[1:2] !stream_pin_o)
        else $error("no start bit after charge cycle");
    a_no_self: assert property (idle && !charge_done && !$past(charge_done) && !$past(charge_done, 2)
        |=> stream_pin_o)
        else $error("frame started without charge cycle");
    a_stand_follow: assert property (!strm && stream_pin_oe && $past(stream_pin_oe)
        |-> stream_pin_o == !$past(sense.flags[FLG_ACT]))
        else $error("standalone pin does not show activation");
    a_motion_follow: assert property ($past(rst_b)
        |-> motion_indicator_pin_oe && motion_indicator_pin_o == !$past(sense.flags[FLG_MOV]))
        else $error("motion pin does not show movement");
    a_wait_first: assert property (req && !$past(req) |-> avs_waitrequest)
        else $error("request answered without wait cycle");
    a_wait_once: assert property (s_held_wait |-> !avs_waitrequest)
        else $error("more than one wait cycle");
endmodule : sws_stream_chk

bind sws_stream_top sws_stream_chk #(.IDLE_CYC(1000)) sws_stream_chk_i (
    .ref_clk(ref_clk), .rst_b(rst_b), .charge_done(charge_done), .sense(sense),
    .motion_sens_code(motion_sens_code), .stream_pin_i(stream_pin_i), .stream_pin_o(stream_pin_o),
    .stream_pin_oe(stream_pin_oe), .motion_indicator_pin_o(motion_indicator_pin_o),
    .motion_indicator_pin_oe(motion_indicator_pin_oe),
    .motion_sensitivity_strap_oe(motion_sensitivity_strap_oe),
    .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest));

//--- dv/sws_stream_rx.sv
`timescale 1ns/10ps
module sws_stream_rx
(
    // Clock and lines
    input  wire logic ref_clk,
    input  wire logic line,
    input  wire logic motion_n,
    // Decoded frame
    output logic [7:0] rx_data [21],
    output int         rx_frames,
    output int         bit_cyc
);
    initial
    begin
        int t;
        rx_frames = 0;
        bit_cyc = 0;
        forever
        begin
            @(negedge line);
            // Frames taken only while movement is shown
            if (motion_n == 1'b0)
            begin
                // Bit time from start plus low first sync bit
                t = 0;
                while (line == 1'b0)
                begin
                    @(negedge ref_clk);
                    t++;
                end
                bit_cyc = t / 2;
                rx_data[0][0] = 1'b0;
                repeat (bit_cyc / 2) @(negedge ref_clk);
                for (int b = 1; b < 8; b++)
                begin
                    rx_data[0][b] = line;
                    repeat (bit_cyc) @(negedge ref_clk);
                end
                // Resync at every start edge, stop length not assumed
                for (int n = 1; n < 21; n++)
                begin
                    @(negedge line);
                    repeat (bit_cyc + bit_cyc / 2) @(negedge ref_clk);
                    for (int b = 0; b < 8; b++)
                    begin
                        rx_data[n][b] = line;
                        repeat (bit_cyc) @(negedge ref_clk);
                    end
                end
                rx_frames++;
            end
        end
    end
endmodule : sws_stream_rx

//--- dv/sws_stream_top_tb.sv
`timescale 1ns/10ps
module sws_stream_top_tb
    import sws_pkg::*;
;
    localparam logic [157:0] PAT = {8'hC5, 64'h1234_5678_9ABC_DEF0, 48'h0F1E_2D3C_4B5A, 6'h2D, 32'h8877_6655};
    logic        ref_clk;
    logic        rst_b;
    logic        charge_done;
    sws_sense_t  sense;
    logic [1:0]  motion_sens_code;
    wire logic   stream_pin_i;
    logic        stream_pin_o;
    logic        stream_pin_oe;
    logic        mot_o;
    logic        mot_oe;
    wire logic   strap_i;
    logic        strap_o;
    logic        strap_oe;
    logic [3:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        pull_up = 1'b0;
    logic [1:0]  strap_mode = MOT_LOW;
    logic        strap_hold = 1'b0;
    logic [1:0]  modes [3] = '{MOT_LOW, MOT_HIGH, MOT_DEF};
    logic [7:0]  rx_data [21];
    logic [31:0] rd;
    int          rx_frames;
    int          bit_cyc;
    int          n_fail = 0;
    int          compares = 0;
    int          cyc = 0;
    int          low_cnt;

    // Released pins: pull level, or charge kept by a floating strap
    assign stream_pin_i = stream_pin_oe ? stream_pin_o : pull_up;
    assign strap_i = strap_oe ? strap_o : (strap_mode == MOT_HIGH) ? 1'b1 : (strap_mode == MOT_LOW) ? 1'b0 : strap_hold;
    always @(posedge ref_clk) if (strap_oe) strap_hold <= strap_o;

    sws_stream_top sws_stream_top_i (
        .ref_clk(ref_clk), .rst_b(rst_b), .charge_done(charge_done), .sense(sense),
        .motion_sens_code(motion_sens_code), .stream_pin_i(stream_pin_i), .stream_pin_o(stream_pin_o),
        .stream_pin_oe(stream_pin_oe), .motion_indicator_pin_o(mot_o), .motion_indicator_pin_oe(mot_oe),
        .motion_sensitivity_strap_i(strap_i), .motion_sensitivity_strap_o(strap_o),
        .motion_sensitivity_strap_oe(strap_oe), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

    sws_stream_rx sws_stream_rx_i (.ref_clk(ref_clk), .line(stream_pin_i), .motion_n(mot_o),
        .rx_data(rx_data), .rx_frames(rx_frames), .bit_cyc(bit_cyc));

    task automatic test_done();
        if (n_fail == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : test_done

    task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask : check

    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] d);
        @(posedge ref_clk);
        avs_address <= a;
        avs_writedata <= wd;
        avs_write <= wr;
        avs_read <= !wr;
        // Held until waitrequest is seen low at a rising edge
        do
        begin
            @(posedge ref_clk);
        end
        while (avs_waitrequest !== 1'b0);
        d = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus

    task automatic do_reset(input logic pu, input logic [1:0] sm);
        @(posedge ref_clk);
        rst_b <= 1'b0;
        pull_up <= pu;
        strap_mode <= sm;
        repeat (6) @(posedge ref_clk);
        rst_b <= 1'b1;
        while (stream_pin_oe !== 1'b1) @(posedge ref_clk);
        repeat (4) @(posedge ref_clk);
    endtask : do_reset

    function automatic logic [7:0] exp_byte(input int n);
        logic [167:0] f;
        f = {8'hAA, sense.flags, sense.ch0_count, sense.ch0_avg, sense.ch1_count, sense.ch1_avg,
             sense.motion_filter, sense.entry_thr, sense.exit_thr, sense.act_level, sense.timer_sel, MOT_DEF,
             sense.mult0, sense.mult1, sense.comp0, sense.comp1};
        return f[167 - 8 * n -: 8];
    endfunction : exp_byte

    initial
    begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            n_fail++;
            test_done();
        end
    end

    initial
    begin
        rst_b = 1'b0;
        charge_done = 1'b0;
        sense = '0;
        avs_address = 4'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0000_0000;
        avs_byteenable = 4'hF;
        for (int m = 0; m < 3; m++)
        begin
            do_reset(m != 0, modes[m]);
            check("motion code", {30'h0, modes[m]}, {30'h0, motion_sens_code});
            bus(1'b0, OFS_STATUS, 32'h0000_0000, rd);
            check("status mode", {29'h0, modes[m], m != 0}, {29'h0, rd[2:0]});
            if (m == 0)
            begin
                sense.flags[FLG_ACT] <= 1'b1;
                repeat (3) @(negedge ref_clk);
                check("standalone pin", 32'h0000_0000, {31'h0, stream_pin_i});
            end
        end
        bus(1'b0, OFS_CTRL, 32'h0000_0000, rd);
        check("ctrl reset", 32'h0000_0001, rd);
        bus(1'b0, OFS_BIT_DIV, 32'h0000_0000, rd);
        check("bit_div reset", 32'h0000_0064, rd);
        avs_byteenable <= 4'h1;
        bus(1'b1, OFS_BIT_DIV, 32'hFFFF_FF04, rd);
        avs_byteenable <= 4'hF;
        bus(1'b1, 4'hC, 32'hFFFF_FFFF, rd);
        bus(1'b0, 4'hC, 32'h0000_0000, rd);
        check("unmapped", 32'h0000_0000, rd);
        bus(1'b0, OFS_BIT_DIV, 32'h0000_0000, rd);
        check("bit_div", 32'h0000_0004, rd);
        for (int f = 0; f < 2; f++)
        begin
            @(posedge ref_clk);
            sense <= sws_sense_t'(PAT ^ {(f == 1) ? 8'h9F : 8'h00, {150{f == 1}}});
            charge_done <= 1'b1;
            @(posedge ref_clk);
            charge_done <= 1'b0;
            repeat (50) @(posedge ref_clk);
            check("motion pin", 32'h0000_0000, {31'h0, mot_o});
            // Second charge cycle inside the first frame is dropped
            charge_done <= (f == 0);
            @(posedge ref_clk);
            charge_done <= 1'b0;
            while (rx_frames < f + 1) @(posedge ref_clk);
            for (int n = 0; n < 21; n++)
                check("stream byte", {24'h0, exp_byte(n)}, {24'h0, rx_data[n]});
            check("bit time", 32'h0000_0004, 32'(bit_cyc));
            low_cnt = 0;
            repeat (40)
            begin
                @(negedge ref_clk);
                low_cnt += (stream_pin_i !== 1'b1);
            end
            check("line after frame", 32'h0000_0000, 32'(low_cnt));
        end
        bus(1'b0, OFS_STATUS, 32'h0000_0000, rd);
        check("status frames", 32'h0000_0213, rd);
        bus(1'b1, OFS_STATUS, 32'h0000_0010, rd);
        bus(1'b0, OFS_STATUS, 32'h0000_0000, rd);
        check("status cleared", 32'h0000_0203, rd);
        test_done();
    end
endmodule : sws_stream_top_tb
